// ---- rtl/rta_pkg.sv ----
// shared offsets, field positions, reset values and event codes for the rtc alarm block
package rta_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_HMODE = 8'h04;
  localparam logic [7:0] OFS_TIME = 8'h08;
  localparam logic [7:0] OFS_CAL = 8'h0c;
  localparam logic [7:0] OFS_TALARM = 8'h10;
  localparam logic [7:0] OFS_CALARM = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_SCLR = 8'h1c;
  localparam logic [7:0] OFS_IEN = 8'h20;
  localparam logic [7:0] OFS_IDIS = 8'h24;
  localparam logic [7:0] OFS_IMASK = 8'h28;
  localparam logic [7:0] OFS_VALID = 8'h2c;
  // status, clear, enable, disable and mask bit positions
  localparam int ST_UPD = 0;
  localparam int ST_ALARM = 1;
  localparam int ST_SEC = 2;
  localparam int ST_TIME_EVENT_FLAG = 3;
  localparam int ST_CALENDAR_EVENT_FLAG = 4;
  localparam int NFLAG = 5;
  // mode and hour mode fields
  localparam int MODE_UPDT = 0;
  localparam int MODE_UPDC = 1;
  localparam int MODE_TEV = 8;
  localparam int MODE_CEV = 16;
  localparam int HM_12H = 0;
  localparam logic [31:0] MODE_MASK = 32'h0003_0303;
  // alarm enable positions and writable masks
  localparam int TA_SEC_EN = 7;
  localparam int TA_MIN_EN = 15;
  localparam int TA_HOUR_EN = 23;
  localparam int CA_MTH_EN = 23;
  localparam int CA_DATE_EN = 31;
  localparam logic [31:0] TALARM_MASK = 32'h00ff_ffff;
  localparam logic [31:0] CALARM_MASK = 32'hbf9f_0000;
  // validity bit positions
  localparam int V_TIME = 0;
  localparam int V_CAL = 1;
  localparam int V_TALARM = 2;
  localparam int V_CALARM = 3;
  localparam int NVALID = 4;
  // reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [NFLAG-1:0] RST_FLAGS = 5'h00;
  localparam logic [NVALID-1:0] RST_VALID = 4'h0;
  // bcd limits for entry checks
  localparam logic [7:0] BCD_ZERO = 8'h00;
  localparam logic [7:0] BCD_ONE = 8'h01;
  localparam logic [7:0] MINSEC_MAX = 8'h59;
  localparam logic [7:0] H24_MAX = 8'h23;
  localparam logic [7:0] H12_MAX = 8'h12;
  localparam logic [7:0] MONTH_MAX = 8'h12;
  localparam logic [7:0] MONTH_FEB = 8'h02;
  localparam logic [7:0] DATE_MAX = 8'h31;
  localparam logic [7:0] DATE_SHORT = 8'h30;
  localparam logic [7:0] DATE_LEAP = 8'h29;
  localparam logic [7:0] DATE_FEB = 8'h28;
  localparam logic [7:0] DAY_MAX = 8'h07;
  localparam logic [7:0] CENT_MIN = 8'h19;
  localparam logic [7:0] CENT_MAX = 8'h20;
  // event selector codes
  typedef enum logic [1:0] {
    TEV_MINUTE = 2'b00, TEV_HOUR = 2'b01, TEV_MIDNIGHT = 2'b10, TEV_NOON = 2'b11
  } rta_tev_e;
  typedef enum logic [1:0] {
    CEV_WEEK = 2'b00, CEV_MONTH = 2'b01, CEV_YEAR = 2'b10, CEV_RSVD = 2'b11
  } rta_cev_e;
endpackage

// ---- rtl/rta_entry_check.sv ----
// bcd range checks for time, calendar and alarm entries
`timescale 1ns/1ps
module rta_entry_check (
  // word under test and hour format
  input wire logic [31:0] wdata,
  input wire logic hour_12,
  // verdicts
  output logic time_ok,
  output logic cal_ok,
  output logic talarm_ok,
  output logic calarm_ok
);
  function automatic logic bcd(input logic [7:0] v);
    return (v[7:4] <= 4'h9) && (v[3:0] <= 4'h9);
  endfunction
  function automatic logic in_rng(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
    return bcd(v) && (v >= lo) && (v <= hi);
  endfunction
  // in 24-hour operation a set meridiem bit is an invalid entry
  function automatic logic hour_good(input logic [7:0] h, input logic pm, input logic h12);
    return h12 ? in_rng(h, rta_pkg::BCD_ONE, rta_pkg::H12_MAX)
               : (in_rng(h, rta_pkg::BCD_ZERO, rta_pkg::H24_MAX) && !pm);
  endfunction

  logic [7:0] sec, min, hour, cent, year, month, day, date, dmax;
  logic leap;

  // field extraction, leap year and month length
  always_comb begin
    sec = {1'b0, wdata[6:0]};
    min = {1'b0, wdata[14:8]};
    hour = {2'b0, wdata[21:16]};
    cent = {1'b0, wdata[6:0]};
    year = wdata[15:8];
    month = {3'b0, wdata[20:16]};
    day = {5'b0, wdata[23:21]};
    date = {2'b0, wdata[29:24]};
    if (year == rta_pkg::BCD_ZERO)
      leap = (cent == rta_pkg::CENT_MAX);
    else if (year[4])
      leap = (year[3:0] == 4'h2) || (year[3:0] == 4'h6);
    else
      leap = (year[3:0] == 4'h0) || (year[3:0] == 4'h4) || (year[3:0] == 4'h8);
    if (month == rta_pkg::MONTH_FEB)
      dmax = leap ? rta_pkg::DATE_LEAP : rta_pkg::DATE_FEB;
    else if (month == 8'h04 || month == 8'h06 || month == 8'h09 || month == 8'h11)
      dmax = rta_pkg::DATE_SHORT;
    else
      dmax = rta_pkg::DATE_MAX;
  end

  // verdicts for each register kind
  always_comb begin
    time_ok = in_rng(sec, rta_pkg::BCD_ZERO, rta_pkg::MINSEC_MAX) &&
              in_rng(min, rta_pkg::BCD_ZERO, rta_pkg::MINSEC_MAX) && hour_good(hour, wdata[22], hour_12);
    talarm_ok = time_ok;
    cal_ok = in_rng(cent, rta_pkg::CENT_MIN, rta_pkg::CENT_MAX) && bcd(year) &&
             in_rng(month, rta_pkg::BCD_ONE, rta_pkg::MONTH_MAX) && in_rng(date, rta_pkg::BCD_ONE, dmax) &&
             in_rng(day, rta_pkg::BCD_ONE, rta_pkg::DAY_MAX);
    calarm_ok = in_rng(month, rta_pkg::BCD_ONE, rta_pkg::MONTH_MAX) &&
                in_rng(date, rta_pkg::BCD_ONE, rta_pkg::DATE_MAX);
  end
endmodule

// ---- rtl/rta_alarm_match.sv ----
// alarm compare of enabled bcd fields against the running counters
`timescale 1ns/1ps
module rta_alarm_match (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // alarm settings and counters
  input wire logic [31:0] talarm,
  input wire logic [31:0] calarm,
  input wire logic [31:0] cur_time,
  input wire logic [31:0] cur_cal,
  // one pulse per entry into match
  output logic hit
);
  logic [4:0] en, eq;
  logic match, prev_reg, prev_next, hit_reg, hit_next;

  // each enabled field must equal its counter; disabled fields are don't care
  always_comb begin
    en = {talarm[rta_pkg::TA_SEC_EN], talarm[rta_pkg::TA_MIN_EN], talarm[rta_pkg::TA_HOUR_EN],
          calarm[rta_pkg::CA_DATE_EN], calarm[rta_pkg::CA_MTH_EN]};
    eq = {talarm[6:0] == cur_time[6:0], talarm[14:8] == cur_time[14:8],
          talarm[22:16] == cur_time[22:16], calarm[29:24] == cur_cal[29:24],
          calarm[20:16] == cur_cal[20:16]};
    match = (|en) && (&(eq | ~en));
    prev_next = match;
    hit_next = match && !prev_reg;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_reg <= 1'b0;
      hit_reg <= 1'b0;
    end else begin
      prev_reg <= prev_next;
      hit_reg <= hit_next;
    end
  end

  assign hit = hit_reg;

  a_hit_once: assert property (@(posedge pclk) disable iff (!presetn) hit_reg |=> !hit_reg)
    else $error("alarm hit lasted more than one cycle");
endmodule

// ---- rtl/rta_top.sv ----
// apb register block for rtc alarm compare, event status, interrupt mask and entry validity
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
module rta_top (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // running counters and their event pulses
  input wire logic [31:0] cur_time,
  input wire logic [31:0] cur_cal,
  input wire logic sec_tick,
  input wire logic min_tick,
  input wire logic hour_tick,
  input wire logic midnight_tick,
  input wire logic noon_tick,
  input wire logic week_tick,
  input wire logic month_tick,
  input wire logic year_tick,
  // counter control
  output logic time_hold,
  output logic cal_hold,
  output logic load_time,
  output logic load_cal,
  output logic [31:0] load_data,
  // interrupt
  output logic irq
);
  // apb group
  logic pready_reg, pready_next, pslverr_reg, pslverr_next;
  logic [31:0] prdata_reg, prdata_next;
  logic setup, wr_en, mapped;
  // control group
  logic [31:0] mode_reg, mode_next, talarm_reg, talarm_next, calarm_reg, calarm_next;
  logic [31:0] load_data_reg, load_data_next;
  logic hmode_reg, hmode_next, load_time_reg, load_time_next, load_cal_reg, load_cal_next;
  logic [rta_pkg::NVALID-1:0] valid_reg, valid_next;
  // status group
  logic [rta_pkg::NFLAG-1:0] status_reg, status_next, mask_reg, mask_next, set, clr, ien, idis;
  logic req_prev_reg, req_prev_next, irq_reg, irq_next, req_any, tev_hit, cev_hit;
  rta_pkg::rta_tev_e tev;
  rta_pkg::rta_cev_e cev;
  // helpers
  logic time_ok, cal_ok, talarm_ok, calarm_ok, alarm_hit;

  rta_entry_check u_check (
    .wdata(pwdata),
    .hour_12(hmode_reg),
    .time_ok(time_ok),
    .cal_ok(cal_ok),
    .talarm_ok(talarm_ok),
    .calarm_ok(calarm_ok)
  );

  rta_alarm_match u_match (
    .pclk(pclk),
    .presetn(presetn),
    .talarm(talarm_reg),
    .calarm(calarm_reg),
    .cur_time(cur_time),
    .cur_cal(cur_cal),
    .hit(alarm_hit)
  );

  // address decode; only aligned word offsets of the map answer without error
  always_comb begin
    setup = psel && !penable;
    wr_en = psel && penable && pwrite && pready_reg;
    case (paddr)
      rta_pkg::OFS_MODE, rta_pkg::OFS_HMODE, rta_pkg::OFS_TIME, rta_pkg::OFS_CAL,
      rta_pkg::OFS_TALARM, rta_pkg::OFS_CALARM, rta_pkg::OFS_STATUS, rta_pkg::OFS_SCLR,
      rta_pkg::OFS_IEN, rta_pkg::OFS_IDIS, rta_pkg::OFS_IMASK, rta_pkg::OFS_VALID: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // apb answer: read data captured in the setup cycle so the access phase never waits
  always_comb begin
    pready_next = setup;
    pslverr_next = setup && !mapped;
    prdata_next = prdata_reg;
    if (setup) begin
      case (paddr)
        rta_pkg::OFS_MODE: prdata_next = mode_reg;
        rta_pkg::OFS_HMODE: prdata_next = {31'b0, hmode_reg};
        rta_pkg::OFS_TIME: prdata_next = cur_time;
        rta_pkg::OFS_CAL: prdata_next = cur_cal;
        rta_pkg::OFS_TALARM: prdata_next = talarm_reg;
        rta_pkg::OFS_CALARM: prdata_next = calarm_reg;
        rta_pkg::OFS_STATUS: prdata_next = {27'b0, status_reg};
        rta_pkg::OFS_IMASK: prdata_next = {27'b0, mask_reg};
        rta_pkg::OFS_VALID: prdata_next = {28'b0, valid_reg};
        default: prdata_next = rta_pkg::RST_WORD;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= rta_pkg::RST_WORD;
    end else begin
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
    end
  end

  // control registers, entry checks and counter loads
  always_comb begin
    mode_next = mode_reg;
    hmode_next = hmode_reg;
    talarm_next = talarm_reg;
    calarm_next = calarm_reg;
    valid_next = valid_reg;
    load_time_next = 1'b0;
    load_cal_next = 1'b0;
    load_data_next = load_data_reg;
    if (wr_en) begin
      case (paddr)
        rta_pkg::OFS_MODE: mode_next = pwdata & rta_pkg::MODE_MASK;
        rta_pkg::OFS_HMODE: hmode_next = pwdata[rta_pkg::HM_12H];
        // counters accept a value only while their update is requested in the mode register
        rta_pkg::OFS_TIME: begin
          if (mode_reg[rta_pkg::MODE_UPDT]) begin
            load_time_next = time_ok;
            valid_next[rta_pkg::V_TIME] = !time_ok;
            if (time_ok) begin
              load_data_next = pwdata;
            end
          end
        end
        rta_pkg::OFS_CAL: begin
          if (mode_reg[rta_pkg::MODE_UPDC]) begin
            load_cal_next = cal_ok;
            valid_next[rta_pkg::V_CAL] = !cal_ok;
            if (cal_ok) begin
              load_data_next = pwdata;
            end
          end
        end
        rta_pkg::OFS_TALARM: begin
          valid_next[rta_pkg::V_TALARM] = !talarm_ok;
          if (talarm_ok) begin
            talarm_next = pwdata & rta_pkg::TALARM_MASK;
          end
        end
        rta_pkg::OFS_CALARM: begin
          valid_next[rta_pkg::V_CALARM] = !calarm_ok;
          if (calarm_ok) begin
            calarm_next = pwdata & rta_pkg::CALARM_MASK;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= rta_pkg::RST_WORD;
      hmode_reg <= 1'b0;
      talarm_reg <= rta_pkg::RST_WORD;
      calarm_reg <= rta_pkg::RST_WORD;
      valid_reg <= rta_pkg::RST_VALID;
      load_time_reg <= 1'b0;
      load_cal_reg <= 1'b0;
      load_data_reg <= rta_pkg::RST_WORD;
    end else begin
      mode_reg <= mode_next;
      hmode_reg <= hmode_next;
      talarm_reg <= talarm_next;
      calarm_reg <= calarm_next;
      valid_reg <= valid_next;
      load_time_reg <= load_time_next;
      load_cal_reg <= load_cal_next;
      load_data_reg <= load_data_next;
    end
  end

  // event selection from the mode register
  always_comb begin
    tev = rta_pkg::rta_tev_e'(mode_reg[rta_pkg::MODE_TEV +: 2]);
    cev = rta_pkg::rta_cev_e'(mode_reg[rta_pkg::MODE_CEV +: 2]);
    case (tev)
      rta_pkg::TEV_MINUTE: tev_hit = min_tick;
      rta_pkg::TEV_HOUR: tev_hit = hour_tick;
      rta_pkg::TEV_MIDNIGHT: tev_hit = midnight_tick;
      rta_pkg::TEV_NOON: tev_hit = noon_tick;
      default: tev_hit = 1'b0;
    endcase
    case (cev)
      rta_pkg::CEV_WEEK: cev_hit = week_tick;
      rta_pkg::CEV_MONTH: cev_hit = month_tick;
      rta_pkg::CEV_YEAR: cev_hit = year_tick;
      default: cev_hit = 1'b0; // reserved code raises nothing
    endcase
  end

  // sticky flags: a set in the clearing cycle wins so no event is lost
  always_comb begin
    req_any = mode_reg[rta_pkg::MODE_UPDT] || mode_reg[rta_pkg::MODE_UPDC];
    req_prev_next = req_any;
    set = rta_pkg::RST_FLAGS;
    set[rta_pkg::ST_UPD] = req_any && !req_prev_reg;
    set[rta_pkg::ST_ALARM] = alarm_hit;
    set[rta_pkg::ST_SEC] = sec_tick;
    set[rta_pkg::ST_TIME_EVENT_FLAG] = tev_hit;
    set[rta_pkg::ST_CALENDAR_EVENT_FLAG] = cev_hit;
    clr = (wr_en && paddr == rta_pkg::OFS_SCLR) ? pwdata[rta_pkg::NFLAG-1:0] : rta_pkg::RST_FLAGS;
    ien = (wr_en && paddr == rta_pkg::OFS_IEN) ? pwdata[rta_pkg::NFLAG-1:0] : rta_pkg::RST_FLAGS;
    idis = (wr_en && paddr == rta_pkg::OFS_IDIS) ? pwdata[rta_pkg::NFLAG-1:0] : rta_pkg::RST_FLAGS;
    status_next = (status_reg & ~clr) | set;
    if (!req_any) begin
      status_next[rta_pkg::ST_UPD] = 1'b0;
    end
    mask_next = (mask_reg | ien) & ~idis;
    irq_next = |(status_reg & mask_reg);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= rta_pkg::RST_FLAGS;
      mask_reg <= rta_pkg::RST_FLAGS;
      req_prev_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      status_reg <= status_next;
      mask_reg <= mask_next;
      req_prev_reg <= req_prev_next;
      irq_reg <= irq_next;
    end
  end

  // outputs straight from flops
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign time_hold = mode_reg[rta_pkg::MODE_UPDT];
  assign cal_hold = mode_reg[rta_pkg::MODE_UPDC];
  assign load_time = load_time_reg;
  assign load_cal = load_cal_reg;
  assign load_data = load_data_reg;
  assign irq = irq_reg;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_sec_sticky: assert property (sec_tick |=> status_reg[rta_pkg::ST_SEC])
    else $error("second tick did not set its flag");
  a_alarm_sets: assert property (alarm_hit |=> status_reg[rta_pkg::ST_ALARM])
    else $error("alarm hit did not set alarm flag");
  a_clear_alarm: assert property (wr_en && paddr == rta_pkg::OFS_SCLR && pwdata[rta_pkg::ST_ALARM] && !alarm_hit
    |=> !status_reg[rta_pkg::ST_ALARM])
    else $error("alarm flag survived a clear");
  a_enable_sets: assert property (wr_en && paddr == rta_pkg::OFS_IEN && pwdata[rta_pkg::ST_SEC]
    |=> mask_reg[rta_pkg::ST_SEC])
    else $error("enable write did not set mask");
  a_disable_clears: assert property (wr_en && paddr == rta_pkg::OFS_IDIS && pwdata[rta_pkg::ST_SEC]
    |=> !mask_reg[rta_pkg::ST_SEC])
    else $error("disable write did not clear mask");
  a_upd_needs_req: assert property (!req_any |=> !status_reg[rta_pkg::ST_UPD])
    else $error("update granted without request");
  a_bad_time_held: assert property (wr_en && paddr == rta_pkg::OFS_TIME && time_hold && !time_ok
    |=> !load_time && valid_reg[rta_pkg::V_TIME])
    else $error("invalid time entry was loaded");
  a_irq_path: assert property (status_reg[rta_pkg::ST_ALARM] && mask_reg[rta_pkg::ST_ALARM]
    ##1 status_reg[rta_pkg::ST_ALARM] |-> irq)
    else $error("interrupt missing for masked flag");
  a_minute_event: assert property (tev == rta_pkg::TEV_MINUTE && min_tick |=> status_reg[rta_pkg::ST_TIME_EVENT_FLAG])
    else $error("minute change did not set time event");

  c_irq_rise: cover property (!irq ##1 irq);
  c_time_load: cover property (load_time);
  c_alarm_flag: cover property (alarm_hit ##1 status_reg[rta_pkg::ST_ALARM]);
  c_bad_cal: cover property (wr_en && paddr == rta_pkg::OFS_CAL && cal_hold && !cal_ok);
endmodule

// ---- test/tb.sv ----
// self-checking testbench for the rtc alarm, event status, mask and validity block
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin comparisons++; if ((got) !== (exp)) begin failures++; \
  $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp); end end
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [31:0] cur_time;
  logic [31:0] cur_cal;
  logic [7:0] ticks = 8'h00;
  logic time_hold;
  logic cal_hold;
  logic load_time;
  logic load_cal;
  logic [31:0] load_data;
  logic irq;
  int failures = 0;
  int comparisons = 0;
  int n_lt = 0;
  int n_lc = 0;
  logic [31:0] last_ld = 32'h0000_0000;
  integer seed;

  // free-running bus clock, 100 ns period
  always #50 pclk = ~pclk;

  rta_top u_rta_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cur_time(cur_time),
    .cur_cal(cur_cal), .sec_tick(ticks[0]), .min_tick(ticks[1]), .hour_tick(ticks[2]),
    .midnight_tick(ticks[3]), .noon_tick(ticks[4]), .week_tick(ticks[5]), .month_tick(ticks[6]),
    .year_tick(ticks[7]), .time_hold(time_hold), .cal_hold(cal_hold), .load_time(load_time),
    .load_cal(load_cal), .load_data(load_data), .irq(irq)
  );

  // counts load pulses so a refused entry shows as a missing pulse
  always @(posedge pclk) begin
    if (load_time === 1'b1) begin
      n_lt++;
      last_ld = load_data;
    end
    if (load_cal === 1'b1) n_lc++;
  end

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // request is held until pready is seen high at an edge
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) `CHK(pready, 1'b1, "no pready")
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    xfer(1'b1, a, d, r, e);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string msg);
    logic [31:0] r;
    logic e;
    xfer(1'b0, a, 32'h0000_0000, r, e);
    `CHK(r, exp, msg)
  endtask

  task automatic pulse(input int k);
    @(posedge pclk);
    ticks[k] <= 1'b1;
    @(posedge pclk);
    ticks <= 8'h00;
  endtask

  task automatic settle(input logic [31:0] t, input logic [31:0] c);
    @(posedge pclk);
    cur_time <= t;
    cur_cal <= c;
    repeat (4) @(posedge pclk);
  endtask

  // mask model: enable ors ones in, disable takes ones out, zeros do nothing
  function automatic logic [4:0] next_mask(input logic [4:0] m, input logic en, input logic [31:0] v);
    return en ? (m | v[4:0]) : (m & ~v[4:0]);
  endfunction

  // flag expected from the selected event; reserved calendar code raises nothing
  function automatic logic [31:0] ev_flag(input int g, input int sel);
    if (g == 0) return 32'h0000_0008;
    return (sel < 3) ? 32'h0000_0010 : 32'h0000_0000;
  endfunction

  task results;
    if (failures == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // watchdog well beyond the few hundred cycles the sequence needs
  initial begin
    #2_000_000;
    failures++;
    results;
  end

  initial begin
    logic [31:0] r;
    logic [31:0] v;
    logic e;
    logic [4:0] msk;
    seed = 6;
    cur_time = $random(seed);
    cur_cal = $random(seed);
    msk = 5'h00;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    // reset values and an unmapped address
    rd_chk(8'h14, 32'h0000_0000, "calarm rst");
    rd_chk(8'h18, 32'h0000_0000, "status rst");
    rd_chk(8'h28, 32'h0000_0000, "mask rst");
    rd_chk(8'h2c, 32'h0000_0000, "valid rst");
    xfer(1'b0, 8'h30, 32'h0000_0000, r, e);
    `CHK(e, 1'b1, "unmapped err")
    // random enable and disable writes against the mask model
    for (int i = 0; i < 10; i++) begin
      v = $random(seed);
      wr(i[0] ? 8'h24 : 8'h20, v);
      msk = next_mask(msk, ~i[0], v);
      rd_chk(8'h28, {27'h0, msk}, "mask");
    end
    wr(8'h28, 32'hffff_ffff);
    rd_chk(8'h28, {27'h0, msk}, "mask ro");
    rd_chk(8'h20, 32'h0000_0000, "wo read");
    wr(8'h24, 32'h0000_001f);
    // sticky flags and selective clear
    wr(8'h00, 32'h0000_0000);
    pulse(0);
    pulse(1);
    pulse(0);
    wr(8'h1c, 32'h0000_0013);
    rd_chk(8'h18, 32'h0000_000c, "sticky");
    wr(8'h1c, 32'h0000_0004);
    rd_chk(8'h18, 32'h0000_0008, "clr sec");
    wr(8'h1c, 32'h0000_0008);
    rd_chk(8'h18, 32'h0000_0000, "clr tev");
    // every selector code, the other ticks must not set the flag
    for (int g = 0; g < 2; g++) begin
      for (int sel = 0; sel < 4; sel++) begin
        wr(8'h00, g ? (sel << 16) : (sel << 8));
        wr(8'h1c, 32'h0000_001f);
        // calendar ticks only exist for codes 0..2, so a wrapped index would hit the selected one
        for (int k = 0; k < 4; k++) if (k != sel && (g == 0 || k < 3)) pulse(g ? 5 + (k % 3) : 1 + k);
        rd_chk(8'h18, 32'h0000_0000, "other ev");
        if (g == 0 || sel < 3) pulse(g ? 5 + sel : 1 + sel);
        rd_chk(8'h18, ev_flag(g, sel), "sel ev");
      end
    end
    // interrupt follows flag and mask together
    wr(8'h1c, 32'h0000_001f);
    wr(8'h00, 32'h0000_0000);
    wr(8'h20, 32'h0000_0004);
    `CHK(irq, 1'b0, "irq idle")
    pulse(0);
    repeat (2) @(posedge pclk);
    `CHK(irq, 1'b1, "irq on")
    wr(8'h24, 32'h0000_0004);
    repeat (2) @(posedge pclk);
    `CHK(irq, 1'b0, "irq masked")
    wr(8'h1c, 32'h0000_001f);
    // time update handshake, loads and entry checks
    wr(8'h00, 32'h0000_0001);
    rd_chk(8'h18, 32'h0000_0001, "ack");
    `CHK(time_hold, 1'b1, "hold")
    wr(8'h1c, 32'h0000_0001);
    rd_chk(8'h18, 32'h0000_0000, "ack clr");
    wr(8'h08, 32'h0012_3456);
    rd_chk(8'h2c, 32'h0000_0000, "time ok");
    `CHK(n_lt, 1, "load")
    `CHK(last_ld, 32'h0012_3456, "load data")
    wr(8'h08, 32'h0025_0000);
    rd_chk(8'h2c, 32'h0000_0001, "time bad");
    `CHK(n_lt, 1, "no load")
    wr(8'h08, 32'h0000_0000);
    rd_chk(8'h2c, 32'h0000_0000, "time fixed");
    wr(8'h00, 32'h0000_0000);
    rd_chk(8'h18, 32'h0000_0000, "ack gone");
    `CHK(time_hold, 1'b0, "run")
    wr(8'h08, 32'h0012_3456);
    // a load would show one cycle after the write edge, so wait past it before counting
    repeat (2) @(posedge pclk);
    `CHK(n_lt, 2, "not held")
    wr(8'h00, 32'h0000_0002);
    @(posedge pclk);
    `CHK(cal_hold, 1'b1, "cal hold")
    wr(8'h0c, 32'h0121_9919);
    // the 30th of february in a non-leap year must be refused
    wr(8'h0c, 32'h3022_9919);
    rd_chk(8'h2c, 32'h0000_0002, "cal bad");
    `CHK(n_lc, 1, "cal load")
    wr(8'h00, 32'h0000_0000);
    // alarm entries: pm bit in 24-hour mode is refused and old value kept
    wr(8'h10, 32'h0040_0000);
    rd_chk(8'h2c, 32'h0000_0006, "talarm bad");
    rd_chk(8'h10, 32'h0000_0000, "talarm kept");
    // second-only alarm, then second plus minute
    wr(8'h10, 32'h0000_00a5);
    settle(32'h0000_0024, 32'h1400_0000);
    wr(8'h1c, 32'h0000_001f);
    rd_chk(8'h18, 32'h0000_0000, "no match");
    settle(32'h0000_0025, 32'h1400_0000);
    rd_chk(8'h18, 32'h0000_0002, "sec match");
    wr(8'h1c, 32'h0000_0002);
    repeat (3) @(posedge pclk);
    rd_chk(8'h18, 32'h0000_0000, "once");
    wr(8'h10, 32'h0000_b0a5);
    repeat (3) @(posedge pclk);
    rd_chk(8'h18, 32'h0000_0000, "min off");
    settle(32'h0000_3025, 32'h1400_0000);
    rd_chk(8'h18, 32'h0000_0002, "min match");
    // date-only calendar alarm
    wr(8'h10, 32'h0000_0000);
    wr(8'h14, 32'h9501_0000);
    rd_chk(8'h14, 32'h9501_0000, "calarm");
    rd_chk(8'h2c, 32'h0000_0002, "valid ok");
    wr(8'h1c, 32'h0000_001f);
    rd_chk(8'h18, 32'h0000_0000, "date off");
    settle(32'h0000_3025, 32'h1500_0000);
    rd_chk(8'h18, 32'h0000_0002, "date match");
    results;
  end
endmodule
